/* File: shared/erc_map.svh */
// register offsets, field positions, reset values for the third-supply control block
// assumes a 32-bit apb slave with byte addresses
`ifndef ERC_MAP_SVH
`define ERC_MAP_SVH
`define ERC_OFF_CTRL 12'h000
`define ERC_OFF_CFG 12'h004
`define ERC_OFF_STAT 12'h008
`define ERC_OFF_MASK 12'h00c
`define ERC_OFF_MODE 12'h010
`define ERC_CTRL_EN 0
`define ERC_CTRL_VSEL 1
`define ERC_CTRL_KEEP 2
`define ERC_CTRL_LATCH 3
`define ERC_CFG_SHARE 0
`define ERC_ST_OC 0
`define ERC_ST_UV 1
`define ERC_ST_FAIL 2
`define ERC_ST_BATUV 3
`define ERC_CTRL_RST 4'h0
`define ERC_MASK_RST 4'h0
`endif

/* File: shared/erc_pkg.sv */
// types for the third-supply control block
// assumes erc_map.svh provides the numeric constants
package erc_pkg;
  typedef enum logic [2:0] {
    ERC_INIT = 3'h0,
    ERC_NORMAL = 3'h1,
    ERC_STOP = 3'h3,
    ERC_SLEEP = 3'h2,
    ERC_RESTART = 3'h6,
    ERC_FAILSAFE = 3'h7
  } erc_mode_t;
  typedef enum logic [1:0] {
    ERC_CFG_NONE = 2'h0,
    ERC_CFG_ALONE = 2'h1,
    ERC_CFG_SHARE = 2'h3
  } erc_cfg_t;
  typedef struct packed {
    logic regOn;
    logic volt33;
    logic hpStage;
    logic lpStage;
  } erc_drive_t;
endpackage

/* File: verilog/erc_ext_reg_ctrl.sv */
// third-supply regulator control: lockable configuration, mode gating, status and irq
// assumes a power-on reset on resetn and sync analog indications on clk_sys
//
// Function
// - enable write in normal mode selects stand-alone configuration
// - share-mode write selects load-sharing configuration
// - first configuration locks; later changes ignored
// - lock cleared only by power-on reset, not soft reset
// - stand-alone: select 0 gives 5.0V, 1 gives 3.3V
// - load sharing ignores the voltage select bit
// - stand-alone: off in init/fail-safe, configurable normal, held otherwise
// - load sharing follows main supply state per mode
// - stop mode keeps share output only with keep-in-stop set
// - battery undervoltage switches off; auto-recovers unless latch-off set
// - status readable in a status register over the bus
// - stop mode: high-power stage follows base current thresholds
// - normal mode: only high-power stage active
// - stand-alone overcurrent only sets the flag, cleared by software
// - change after share mode sets command-fail, keeps configuration
// - stand-alone ignores configuration change silently, on/off still allowed
// - stand-alone third-supply undervoltage while switched on sets the undervoltage flag
//
// Local design decisions: the APB register port and the register offsets.
`timescale 1ns/1ps
`include "erc_map.svh"
module erc_ext_reg_ctrl (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic softResetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire erc_pkg::erc_mode_t chipMode,
  input wire logic mainSupplyOn,
  input wire logic batteryUv,
  input wire logic shuntLimit,
  input wire logic extRegUv,
  input wire logic baseCurHigh,
  input wire logic baseCurLow,
  output erc_pkg::erc_drive_t drive,
  output logic irq
);
  // ===========================================================
  // bus decode
  logic wrEn, rdEn, hit;
  assign wrEn = psel && penable && pwrite && pstrb[0];
  assign rdEn = psel && penable && !pwrite;
  assign hit = paddr == `ERC_OFF_CTRL || paddr == `ERC_OFF_CFG || paddr == `ERC_OFF_STAT ||
               paddr == `ERC_OFF_MASK || paddr == `ERC_OFF_MODE;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;

  // ===========================================================
  // state
  logic [3:0] ctrl_q, ctrl_d, mask_q, mask_d, stat_q, stat_d;
  erc_pkg::erc_cfg_t cfg_q, cfg_d;
  logic on_q, on_d, batLatch_q, batLatch_d, hp_q, hp_d;
  logic [31:0] prdata_d;
  erc_pkg::erc_drive_t drive_d;
  logic wCtrl, wCfg, wStat, wMask;
  logic cfgChange, failEv, ocEv, uvEv, batEv;
  assign wCtrl = wrEn && paddr == `ERC_OFF_CTRL;
  assign wCfg = wrEn && paddr == `ERC_OFF_CFG;
  assign wStat = wrEn && paddr == `ERC_OFF_STAT;
  assign wMask = wrEn && paddr == `ERC_OFF_MASK;

  always_comb begin
    ctrl_d = ctrl_q;
    mask_d = mask_q;
    cfg_d = cfg_q;
    cfgChange = 1'b0;
    if (wMask) begin
      mask_d = pwdata[3:0];
    end
    if (wCtrl) begin
      ctrl_d = pwdata[3:0];
    end
    // configuration lock: only the first selection is taken
    if (cfg_q == erc_pkg::ERC_CFG_NONE) begin
      if (wCfg && pwdata[`ERC_CFG_SHARE]) begin
        cfg_d = erc_pkg::ERC_CFG_SHARE;
      end else if (wCtrl && pwdata[`ERC_CTRL_EN] && chipMode == erc_pkg::ERC_NORMAL) begin
        cfg_d = erc_pkg::ERC_CFG_ALONE;
      end
    end else begin
      // a change means a share-bit write that differs from the locked choice, or an enable write while locked to sharing
      cfgChange = wCfg && (pwdata[`ERC_CFG_SHARE] != (cfg_q == erc_pkg::ERC_CFG_SHARE));
      if (cfg_q == erc_pkg::ERC_CFG_SHARE && wCtrl && pwdata[`ERC_CTRL_EN]) begin
        cfgChange = 1'b1;
      end
    end
  end
  assign failEv = cfgChange && cfg_q == erc_pkg::ERC_CFG_SHARE;
  assign ocEv = shuntLimit && cfg_q == erc_pkg::ERC_CFG_ALONE;
  assign uvEv = extRegUv && cfg_q == erc_pkg::ERC_CFG_ALONE && on_q;
  assign batEv = batteryUv && cfg_q != erc_pkg::ERC_CFG_NONE;

  // ===========================================================
  // status: set wins over write-one clear
  always_comb begin
    stat_d = stat_q;
    if (wStat) begin
      stat_d = stat_q & ~pwdata[3:0];
    end
    stat_d = stat_d | {batEv, failEv, uvEv, ocEv};
  end

  // ===========================================================
  // output gating per mode
  always_comb begin
    on_d = on_q;
    batLatch_d = batLatch_q;
    hp_d = hp_q;
    if (batteryUv && cfg_q != erc_pkg::ERC_CFG_NONE && ctrl_q[`ERC_CTRL_LATCH]) begin
      batLatch_d = 1'b1;
    end
    if (wCtrl && !pwdata[`ERC_CTRL_LATCH]) begin
      batLatch_d = 1'b0;
    end
    unique case (cfg_q)
      erc_pkg::ERC_CFG_ALONE: begin
        unique case (chipMode)
          erc_pkg::ERC_INIT, erc_pkg::ERC_FAILSAFE: on_d = 1'b0;
          erc_pkg::ERC_NORMAL: on_d = ctrl_q[`ERC_CTRL_EN];
          default: on_d = on_q;
        endcase
      end
      erc_pkg::ERC_CFG_SHARE: begin
        unique case (chipMode)
          erc_pkg::ERC_NORMAL: on_d = mainSupplyOn;
          erc_pkg::ERC_RESTART: on_d = 1'b1;
          erc_pkg::ERC_STOP: on_d = mainSupplyOn && ctrl_q[`ERC_CTRL_KEEP];
          default: on_d = 1'b0;
        endcase
      end
      default: on_d = 1'b0;
    endcase
    // stop mode hysteresis between the two stages
    if (chipMode == erc_pkg::ERC_STOP) begin
      if (baseCurHigh) begin
        hp_d = 1'b1;
      end else if (baseCurLow) begin
        hp_d = 1'b0;
      end
    end else begin
      hp_d = chipMode == erc_pkg::ERC_NORMAL;
    end
  end

  always_comb begin
    drive_d.regOn = on_q && !batteryUv && !batLatch_q;
    drive_d.volt33 = cfg_q == erc_pkg::ERC_CFG_ALONE && ctrl_q[`ERC_CTRL_VSEL];
    drive_d.hpStage = drive_d.regOn && hp_q;
    drive_d.lpStage = drive_d.regOn && chipMode != erc_pkg::ERC_NORMAL;
    prdata_d = 32'h0;
    if (rdEn) begin
      unique case (paddr)
        `ERC_OFF_CTRL: prdata_d = {28'h0, ctrl_q};
        `ERC_OFF_CFG: prdata_d = {30'h0, cfg_q};
        `ERC_OFF_STAT: prdata_d = {27'h0, drive.regOn, stat_q};
        `ERC_OFF_MASK: prdata_d = {28'h0, mask_q};
        `ERC_OFF_MODE: prdata_d = {29'h0, chipMode};
        default: prdata_d = 32'h0;
      endcase
    end
  end
  assign prdata = prdata_d;

  // ===========================================================
  // registers: lock state sees only the power-on reset
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cfg_q <= erc_pkg::ERC_CFG_NONE;
    end else begin
      cfg_q <= cfg_d;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ctrl_q <= `ERC_CTRL_RST;
      mask_q <= `ERC_MASK_RST;
      stat_q <= 4'h0;
      on_q <= 1'b0;
      batLatch_q <= 1'b0;
      hp_q <= 1'b0;
      drive <= '0;
      irq <= 1'b0;
    end else if (!softResetn) begin
      ctrl_q <= `ERC_CTRL_RST;
      mask_q <= `ERC_MASK_RST;
      stat_q <= 4'h0;
      on_q <= 1'b0;
      batLatch_q <= 1'b0;
      hp_q <= 1'b0;
      drive <= '0;
      irq <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      mask_q <= mask_d;
      stat_q <= stat_d;
      on_q <= on_d;
      batLatch_q <= batLatch_d;
      hp_q <= hp_d;
      drive <= drive_d;
      irq <= |(stat_d & mask_d);
    end
  end

  // ===========================================================
  // checks
  sequence s_lockedAlone;
    cfg_q == erc_pkg::ERC_CFG_ALONE;
  endsequence
  a_cfg_lock_hold: assert property (@(posedge clk_sys) disable iff (!resetn)
    cfg_q != erc_pkg::ERC_CFG_NONE |=> $stable(cfg_q)) else $error("config changed");
  a_share_select: assert property (@(posedge clk_sys) disable iff (!resetn)
    cfg_q == erc_pkg::ERC_CFG_NONE && wCfg && pwdata[0] |=> cfg_q == erc_pkg::ERC_CFG_SHARE)
    else $error("share not selected");
  a_alone_select: assert property (@(posedge clk_sys) disable iff (!resetn)
    cfg_q == erc_pkg::ERC_CFG_NONE && !wCfg && wCtrl && pwdata[0] &&
    chipMode == erc_pkg::ERC_NORMAL |=> s_lockedAlone) else $error("alone not selected");
  a_fail_flag: assert property (@(posedge clk_sys) disable iff (!resetn || !softResetn)
    failEv |=> stat_q[`ERC_ST_FAIL]) else $error("fail flag missing");
  a_no_fail_alone: assert property (@(posedge clk_sys) disable iff (!resetn || !softResetn)
    s_lockedAlone |-> !failEv) else $error("fail in stand-alone");
  a_off_bat_uv: assert property (@(posedge clk_sys) disable iff (!resetn)
    batteryUv |=> !drive.regOn) else $error("on under battery uv");
  a_off_init: assert property (@(posedge clk_sys) disable iff (!resetn)
    chipMode == erc_pkg::ERC_INIT [*2] |=> !drive.regOn) else $error("on in init");
  a_volt_share: assert property (@(posedge clk_sys) disable iff (!resetn)
    cfg_q == erc_pkg::ERC_CFG_SHARE |=> !drive.volt33) else $error("vsel in share");
  a_oc_flag: assert property (@(posedge clk_sys) disable iff (!resetn || !softResetn)
    ocEv |=> stat_q[`ERC_ST_OC]) else $error("oc flag missing");
  a_uv_flag: assert property (@(posedge clk_sys) disable iff (!resetn || !softResetn)
    uvEv |=> stat_q[`ERC_ST_UV]) else $error("uv flag missing");
  a_stop_keep: assert property (@(posedge clk_sys) disable iff (!resetn)
    cfg_q == erc_pkg::ERC_CFG_SHARE && chipMode == erc_pkg::ERC_STOP && !ctrl_q[2] |=> !on_q)
    else $error("share on in stop");
  a_normal_hp: assert property (@(posedge clk_sys) disable iff (!resetn || !softResetn)
    chipMode == erc_pkg::ERC_NORMAL [*2] |=> !drive.lpStage) else $error("lp in normal");
  a_stop_hp_up: assert property (@(posedge clk_sys) disable iff (!resetn || !softResetn)
    chipMode == erc_pkg::ERC_STOP && baseCurHigh |=> hp_q) else $error("hp not raised");

  // ===========================================================
  // more checks: mode gating per configuration, stop hysteresis, lock, latch-off, battery flag and irq
  // share steps are built from one sequence so each mode row reads the same
  sequence s_shareIn(erc_pkg::erc_mode_t m);
    cfg_q == erc_pkg::ERC_CFG_SHARE && chipMode == m;
  endsequence
  sequence s_aloneIn(erc_pkg::erc_mode_t m);
    cfg_q == erc_pkg::ERC_CFG_ALONE && chipMode == m;
  endsequence
  sequence s_lockedShare;
    cfg_q == erc_pkg::ERC_CFG_SHARE;
  endsequence
  a_stop_hp_down: assert property (@(posedge clk_sys) disable iff (!resetn || !softResetn)
    chipMode == erc_pkg::ERC_STOP && !baseCurHigh && baseCurLow |=> !hp_q)
    else $error("hp not lowered");
  a_share_keep_cfg: assert property (@(posedge clk_sys) disable iff (!resetn)
    s_lockedShare |=> cfg_q == erc_pkg::ERC_CFG_SHARE) else $error("share config lost");
  a_alone_off_fs: assert property (@(posedge clk_sys) disable iff (!resetn)
    s_aloneIn(erc_pkg::ERC_FAILSAFE) |=> !on_q) else $error("alone on in fail-safe");
  a_alone_en_follow: assert property (@(posedge clk_sys) disable iff (!resetn || !softResetn)
    s_aloneIn(erc_pkg::ERC_NORMAL) |=> on_q == $past(ctrl_q[`ERC_CTRL_EN]))
    else $error("enable not followed");
  a_alone_volt: assert property (@(posedge clk_sys) disable iff (!resetn || !softResetn)
    s_lockedAlone |=> drive.volt33 == $past(ctrl_q[`ERC_CTRL_VSEL]))
    else $error("voltage select wrong");
  a_share_restart: assert property (@(posedge clk_sys) disable iff (!resetn || !softResetn)
    s_shareIn(erc_pkg::ERC_RESTART) |=> on_q) else $error("share off in restart");
  a_share_sleep: assert property (@(posedge clk_sys) disable iff (!resetn)
    s_shareIn(erc_pkg::ERC_SLEEP) |=> !on_q) else $error("share on in sleep");
  a_share_stop_keep: assert property (@(posedge clk_sys) disable iff (!resetn || !softResetn)
    s_shareIn(erc_pkg::ERC_STOP) ##0 ctrl_q[`ERC_CTRL_KEEP] && mainSupplyOn |=> on_q)
    else $error("share dropped in stop");
  // an unlocked block must never power the external stage
  a_none_off: assert property (@(posedge clk_sys) disable iff (!resetn)
    cfg_q == erc_pkg::ERC_CFG_NONE |=> !on_q) else $error("on without config");
  a_latch_off: assert property (@(posedge clk_sys) disable iff (!resetn)
    batLatch_q |=> !drive.regOn) else $error("on while latched off");
  a_bat_flag: assert property (@(posedge clk_sys) disable iff (!resetn || !softResetn)
    batEv |=> stat_q[`ERC_ST_BATUV]) else $error("battery flag missing");
  // irq is registered from the next status, so it tracks the stored flags exactly
  a_irq_level: assert property (@(posedge clk_sys) disable iff (!resetn)
    irq == |(stat_q & mask_q)) else $error("irq level wrong");
endmodule // erc_ext_reg_ctrl

/* File: verif/erc_host_model.sv */
// apb host model: the microcontroller side of the register bus
// assumes clk_sys from the bench and a slave that answers through pready
`timescale 1ns/1ps
module erc_host_model (
  input wire logic clk_sys,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb,
  input wire logic pready
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    pstrb = 4'hf;
  end
  // ==========
  // one transfer, held until pready is sampled high
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    psel <= 1'b0;
    penable <= 1'b0;
    // released data must not look like the last value
    pwdata <= ~d;
    @(posedge clk_sys);
  endtask
endmodule // erc_host_model

/* File: verif/testbench.sv */
// bench for the third-supply control block
// assumes erc_host_model drives the apb side; drive settles in 2 cycles
`timescale 1ns/1ps
`include "erc_map.svh"
module testbench;
  logic clk_sys, resetn, softResetn, mainSupplyOn, batteryUv, shuntLimit, extRegUv;
  logic baseCurHigh, baseCurLow, psel, penable, pwrite, pready, pslverr, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  erc_pkg::erc_mode_t chipMode;
  erc_pkg::erc_drive_t drive;
  logic [32:0] expQ[$];
  int failures, n_compared;
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  erc_host_model u_host (.clk_sys(clk_sys), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready));
  erc_ext_reg_ctrl u_dut (.clk_sys(clk_sys), .resetn(resetn), .softResetn(softResetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .chipMode(chipMode),
    .mainSupplyOn(mainSupplyOn), .batteryUv(batteryUv), .shuntLimit(shuntLimit),
    .extRegUv(extRegUv), .baseCurHigh(baseCurHigh), .baseCurLow(baseCurLow), .drive(drive),
    .irq(irq));
  // ==========
  // tasks
  task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // upper control bits are random: they must read back as zero
  function automatic logic [31:0] rc(input logic [3:0] v);
    return ($urandom() & 32'hfffffff0) | {28'h0, v};
  endfunction
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    u_host.xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    expQ.push_back(e);
    u_host.xfer(1'b0, a, 32'h0);
  endtask
  task automatic dv(input logic [3:0] e, input logic [3:0] m);
    repeat (4) @(posedge clk_sys);
    cmp({29'h0, drive & m}, {29'h0, e});
  endtask
  task automatic sm(input erc_pkg::erc_mode_t m, input logic e);
    chipMode <= m;
    dv({e, 3'h0}, 4'h8);
  endtask
  task automatic pulse(input int k);
    if (k == 0) shuntLimit <= 1'b1;
    else extRegUv <= 1'b1;
    @(posedge clk_sys);
    shuntLimit <= 1'b0;
    extRegUv <= 1'b0;
  endtask
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // ==========
  // read monitor: oldest note against each read answer
  always @(posedge clk_sys) begin
    if (psel && penable && pready && !pwrite) begin
      if (expQ.size() == 0) cmp({pslverr, prdata}, 33'h1ffffffff);
      else cmp({pslverr, prdata}, expQ.pop_front());
    end
  end
  initial begin
    #400us;
    failures++;
    results();
  end
  // ==========
  // main sequence
  initial begin
    resetn = 1'b0;
    softResetn = 1'b1;
    chipMode = erc_pkg::ERC_INIT;
    mainSupplyOn = 1'b1;
    batteryUv = 1'b0;
    shuntLimit = 1'b0;
    extRegUv = 1'b0;
    baseCurHigh = 1'b0;
    baseCurLow = 1'b1;
    failures = 0;
    n_compared = 0;
    void'($urandom(32'h5f38b301));
    repeat (16) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    rd(`ERC_OFF_CTRL, 33'h0);
    rd(`ERC_OFF_MASK, 33'h0);
    rd(12'h040, 33'h100000000);
    chipMode <= erc_pkg::ERC_NORMAL;
    wr(`ERC_OFF_CTRL, rc(4'h1));
    rd(`ERC_OFF_CFG, 33'h1);
    dv(4'ha, 4'hf);
    wr(`ERC_OFF_CTRL, rc(4'h3));
    dv(4'he, 4'hf);
    wr(`ERC_OFF_CFG, 32'h1);
    rd(`ERC_OFF_CFG, 33'h1);
    rd(`ERC_OFF_STAT, 33'h10);
    wr(`ERC_OFF_CTRL, rc(4'h0));
    dv(4'h0, 4'h8);
    wr(`ERC_OFF_CTRL, rc(4'h1));
    dv(4'ha, 4'hf);
    $display("test stand-alone config done");
    chipMode <= erc_pkg::ERC_STOP;
    dv(4'h9, 4'hf);
    baseCurHigh <= 1'b1;
    baseCurLow <= 1'b0;
    dv(4'h2, 4'h2);
    baseCurHigh <= 1'b0;
    baseCurLow <= 1'b1;
    dv(4'h0, 4'h2);
    sm(erc_pkg::ERC_SLEEP, 1'b1);
    sm(erc_pkg::ERC_RESTART, 1'b1);
    sm(erc_pkg::ERC_FAILSAFE, 1'b0);
    sm(erc_pkg::ERC_INIT, 1'b0);
    sm(erc_pkg::ERC_NORMAL, 1'b1);
    $display("test mode gating done");
    wr(`ERC_OFF_MASK, 32'h1);
    pulse(0);
    dv(4'ha, 4'hf);
    cmp({32'h0, irq}, 33'h1);
    pulse(1);
    rd(`ERC_OFF_STAT, 33'h13);
    wr(`ERC_OFF_STAT, 32'h1);
    rd(`ERC_OFF_STAT, 33'h12);
    cmp({32'h0, irq}, 33'h0);
    wr(`ERC_OFF_STAT, 32'hf);
    batteryUv <= 1'b1;
    dv(4'h0, 4'h8);
    batteryUv <= 1'b0;
    dv(4'h8, 4'h8);
    rd(`ERC_OFF_STAT, 33'h18);
    wr(`ERC_OFF_CTRL, rc(4'h9));
    batteryUv <= 1'b1;
    dv(4'h0, 4'h8);
    batteryUv <= 1'b0;
    dv(4'h0, 4'h8);
    wr(`ERC_OFF_CTRL, rc(4'h1));
    dv(4'h8, 4'h8);
    $display("test events done");
    softResetn <= 1'b0;
    @(posedge clk_sys);
    softResetn <= 1'b1;
    @(posedge clk_sys);
    rd(`ERC_OFF_CFG, 33'h1);
    resetn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    rd(`ERC_OFF_CFG, 33'h0);
    wr(`ERC_OFF_CFG, 32'h1);
    rd(`ERC_OFF_CFG, 33'h3);
    wr(`ERC_OFF_CTRL, rc(4'h3));
    rd(`ERC_OFF_STAT, 33'h14);
    rd(`ERC_OFF_CFG, 33'h3);
    dv(4'ha, 4'hf);
    sm(erc_pkg::ERC_STOP, 1'b0);
    wr(`ERC_OFF_CTRL, rc(4'h4));
    dv(4'h8, 4'h8);
    sm(erc_pkg::ERC_SLEEP, 1'b0);
    sm(erc_pkg::ERC_RESTART, 1'b1);
    sm(erc_pkg::ERC_FAILSAFE, 1'b0);
    sm(erc_pkg::ERC_NORMAL, 1'b1);
    mainSupplyOn <= 1'b0;
    dv(4'h0, 4'h8);
    $display("test load sharing done");
    results();
  end
endmodule // testbench
